// ### design/mni_buf2.sv
// Two-entry skid buffer with registered outputs
`timescale 1ns/1ps
module mni_buf2 #(
    parameter int WIDTH = 9
) (
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             arst_n_i,
    // Filling side
    input  wire logic             in_valid_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  in_ready_o,
    // Draining side
    output logic                  out_valid_o,
    output logic [WIDTH-1:0]      out_data_o,
    input  wire logic             out_ready_i
);
    logic             skid_v;
    logic [WIDTH-1:0] skid_d;
    logic             next_out_v;
    logic [WIDTH-1:0] next_out_d;
    logic             next_skid_v;
    logic [WIDTH-1:0] next_skid_d;
    logic             in_fire;

    always_comb begin
        in_fire     = in_valid_i & ~skid_v;
        next_out_v  = out_valid_o;
        next_out_d  = out_data_o;
        next_skid_v = skid_v;
        next_skid_d = skid_d;
        if (out_ready_i || !out_valid_o) begin
            if (skid_v) begin
                next_out_v  = 1'b1;
                next_out_d  = skid_d;
                next_skid_v = 1'b0;
            end else begin
                next_out_v = in_fire;
                if (in_fire) begin
                    next_out_d = in_data_i;
                end
            end
        end else if (in_fire) begin
            // Head is stalled: park the word instead of losing it
            next_skid_v = 1'b1;
            next_skid_d = in_data_i;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            out_valid_o <= 1'b0;
            out_data_o  <= '0;
            skid_v      <= 1'b0;
            skid_d      <= '0;
            in_ready_o  <= 1'b1;
        end else begin
            out_valid_o <= next_out_v;
            out_data_o  <= next_out_d;
            skid_v      <= next_skid_v;
            skid_d      <= next_skid_d;
            in_ready_o  <= ~next_skid_v;
        end
    end
endmodule

// ### design/mni_top.sv
// MAC-side nibble interface toward an internal or external PHY
`timescale 1ns/1ps
`include "mni_defines.svh"

// Functional notes
// RULE1: Both nibble clocks come from the PHY, at 25 MHz or 2.5 MHz.
// RULE2: Transmit enable rises together with the first preamble nibble.
// RULE3: Transmit nibble bit 0 is the byte's low bit, sent first.
// RULE4: Transmit enable and data change only on transmit clock rising edges.
// RULE5: Transmit enable drops at the end of the last checksum nibble.
// RULE6: Collision is asynchronous and synchronised before use.
// RULE7: The PHY raises receive valid with preamble or flag nibbles present.
// RULE8: One flag octet suffices to accept a frame, no longer preamble needed.
// RULE9: Receive valid and data are sampled on receive clock rising edges.
// RULE10: Receive nibble bit 0 is the least significant bit.
// RULE11: The PHY drops receive valid after the final checksum nibble.
// RULE12: Receive error anywhere in a frame discards it as a checksum error.
// RULE13: The PHY keeps nibbles aligned; no realignment is done here.
// RULE14: The opening flag is nibble 5 then D; other junk is tolerated.
// RULE15: Carrier sense only gates deferral, never receive framing.
// RULE16: Carrier sense is asynchronous, synchronised, and includes own traffic.
// RULE17: External PHY select resets to zero, choosing the integrated PHY.
// RULE18: The integrated PHY answers at management address zero.
// RULE19: The integrated PHY is isolated from reset until software clears it.
// RULE20: Selecting the external PHY isolates the integrated one.
// RULE21: An isolated integrated PHY ignores inputs and floats its outputs.
module mni_top
    import mni_pkg::*;
(
    // Clock and reset
    input  wire logic       ref_clk_i,
    input  wire logic       arst_n_i,
    // Software control
    input  wire logic       external_phy_select_i,
    input  wire logic       phy_disable_clear_i,
    input  wire logic       phy_disable_set_i,
    // Transmit byte stream
    input  wire logic [7:0] tx_data_i,
    input  wire logic       tx_valid_i,
    input  wire logic       tx_last_i,
    output logic            tx_ready_o,
    output logic            tx_collision_o,
    output logic            tx_underrun_o,
    // Transmit pins
    input  wire logic       tx_nibble_clock_i,
    input  wire logic       collision_in_i,
    input  wire logic       carrier_sense_in_i,
    output logic            tx_enable_out_o,
    output logic [3:0]      txd_o,
    output logic            mii_tx_oe_o,
    // Receive pins
    input  wire logic       rx_nibble_clock_i,
    input  wire logic       rx_dv_i,
    input  wire logic       rx_er_i,
    input  wire logic [3:0] rxd_i,
    // Receive byte stream
    output logic [7:0]      rx_data_o,
    output logic            rx_valid_o,
    output logic            rx_end_o,
    output logic            rx_fcs_err_o,
    output logic            carrier_o,
    // Integrated PHY control
    output logic            external_phy_select_o,
    output logic            phy_interface_disable_o,
    output logic            int_phy_isolate_o,
    output logic [4:0]      int_phy_addr_o
);
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!arst_n_i);

    // Synchronisers: stage one feeds stage two only
    logic [`MNI_SYNC_W-1:0] pins;
    logic [`MNI_SYNC_W-1:0] sync1;
    logic [`MNI_SYNC_W-1:0] sync2;
    logic [`MNI_SYNC_W-1:0] sync3;
    logic                   tx_tick;
    logic                   rx_tick;
    logic                   col_s;
    logic                   dv_s;
    logic                   er_s;
    mni_nib_t               nib_s;

    assign pins = {tx_nibble_clock_i, rx_nibble_clock_i, collision_in_i,
                   carrier_sense_in_i, rx_dv_i, rx_er_i, rxd_i};

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sync1 <= '0;
            sync2 <= '0;
            sync3 <= '0;
        end else begin
            sync1 <= pins;
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    // RULE1: edges of PHY clocks
    // RULE4: transmit side acts on this edge
    assign tx_tick = sync2[`MNI_POS_TXC] & ~sync3[`MNI_POS_TXC];
    // RULE9: receive sampling edge
    assign rx_tick = sync2[`MNI_POS_RXC] & ~sync3[`MNI_POS_RXC];
    // RULE6: collision after two flops
    assign col_s   = sync2[`MNI_POS_COL];
    // Data captured just before the clock rise is the settled value
    assign dv_s    = sync3[`MNI_POS_DV];
    assign er_s    = sync3[`MNI_POS_ER];
    assign nib_s   = sync3[`MNI_POS_RXD_HI:`MNI_POS_RXD_LO];

    // PHY selection and isolation
    logic next_ext_sel;
    logic next_phy_dis;
    logic next_isolate;

    always_comb begin
        // RULE17: follows the software select
        next_ext_sel = external_phy_select_i;
        next_phy_dis = phy_interface_disable_o;
        // RULE19: only software clears isolation
        if (phy_disable_set_i) begin
            next_phy_dis = 1'b1;
        end else if (phy_disable_clear_i) begin
            next_phy_dis = 1'b0;
        end
        // RULE20: external select isolates the integrated PHY
        // RULE21: isolation floats the integrated PHY's outputs
        next_isolate = phy_interface_disable_o | external_phy_select_o;
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            external_phy_select_o   <= `MNI_EXT_SEL_RST;
            mii_tx_oe_o             <= `MNI_EXT_SEL_RST;
            phy_interface_disable_o <= `MNI_PHY_INTERFACE_DISABLE_RST;
            int_phy_isolate_o       <= `MNI_PHY_INTERFACE_DISABLE_RST;
            int_phy_addr_o          <= `MNI_INT_PHY_ADDR;
        end else begin
            external_phy_select_o   <= next_ext_sel;
            mii_tx_oe_o             <= next_ext_sel;
            phy_interface_disable_o <= next_phy_dis;
            int_phy_isolate_o       <= next_isolate;
            // RULE18: fixed management address
            int_phy_addr_o          <= `MNI_INT_PHY_ADDR;
        end
    end

    // RULE16: carrier registered for deferral
    logic next_carrier;
    always_comb begin
        next_carrier = sync2[`MNI_POS_CRS];
    end
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            carrier_o <= 1'b0;
        end else begin
            carrier_o <= next_carrier;
        end
    end

    // Transmit buffer
    logic                  bo_valid;
    logic [`MNI_BUF_W-1:0] bo_data;
    logic                  pop;

    mni_buf2 #(
        .WIDTH(`MNI_BUF_W)
    ) u_txbuf (
        .clk_i      (ref_clk_i),
        .arst_n_i   (arst_n_i),
        .in_valid_i (tx_valid_i),
        .in_data_i  ({tx_last_i, tx_data_i}),
        .in_ready_o (tx_ready_o),
        .out_valid_o(bo_valid),
        .out_data_o (bo_data),
        .out_ready_i(pop)
    );

    // Transmit engine
    mni_tx_e  tx_state;
    mni_tx_e  next_tx_state;
    logic [3:0] tx_cnt;
    logic [3:0] next_tx_cnt;
    logic       tx_hi;
    logic       next_tx_hi;
    logic       tx_fin;
    logic       next_tx_fin;
    logic [7:0] tx_cur;
    logic [7:0] next_tx_cur;
    logic       next_tx_en;
    mni_nib_t   next_txd;
    logic       next_col;
    logic       next_und;

    always_comb begin
        next_tx_state = tx_state;
        next_tx_cnt   = tx_cnt;
        next_tx_hi    = tx_hi;
        next_tx_fin   = tx_fin;
        next_tx_cur   = tx_cur;
        next_tx_en    = tx_enable_out_o;
        next_txd      = txd_o;
        next_col      = tx_collision_o;
        next_und      = 1'b0;
        pop           = 1'b0;
        if (tx_tick) begin
            next_col = tx_enable_out_o & col_s;
            unique case (tx_state)
                TX_IDLE: begin
                    // RULE15: defer while the cable is busy
                    if (bo_valid && !carrier_o) begin
                        // RULE2: enable with first preamble nibble
                        next_tx_en    = 1'b1;
                        next_txd      = `MNI_PRE_NIB;
                        next_tx_cnt   = `MNI_CNT_FIRST;
                        next_tx_state = TX_PRE;
                    end
                end
                TX_PRE: begin
                    next_tx_cnt = tx_cnt + 4'h1;
                    if (tx_cnt == `MNI_PRE_LAST) begin
                        next_txd      = `MNI_SFD_NIB;
                        next_tx_hi    = 1'b0;
                        next_tx_fin   = 1'b0;
                        next_tx_state = TX_DATA;
                    end else begin
                        next_txd = `MNI_PRE_NIB;
                    end
                end
                TX_DATA: begin
                    if (tx_hi) begin
                        next_txd   = tx_cur[7:4];
                        next_tx_hi = 1'b0;
                    end else if (tx_fin) begin
                        // RULE5: close after the final nibble
                        next_tx_en    = 1'b0;
                        next_tx_state = TX_IDLE;
                    end else if (bo_valid) begin
                        // RULE3: low nibble goes out first
                        pop         = 1'b1;
                        next_txd    = bo_data[3:0];
                        next_tx_cur = bo_data[7:0];
                        next_tx_fin = bo_data[8];
                        next_tx_hi  = 1'b1;
                    end else begin
                        // Source ran dry mid-frame: end the frame
                        next_tx_en    = 1'b0;
                        next_und      = 1'b1;
                        next_tx_state = TX_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            tx_state        <= TX_IDLE;
            tx_cnt          <= '0;
            tx_hi           <= 1'b0;
            tx_fin          <= 1'b0;
            tx_cur          <= '0;
            tx_enable_out_o <= 1'b0;
            txd_o           <= '0;
            tx_collision_o  <= 1'b0;
            tx_underrun_o   <= 1'b0;
        end else begin
            tx_state        <= next_tx_state;
            tx_cnt          <= next_tx_cnt;
            tx_hi           <= next_tx_hi;
            tx_fin          <= next_tx_fin;
            tx_cur          <= next_tx_cur;
            tx_enable_out_o <= next_tx_en;
            txd_o           <= next_txd;
            tx_collision_o  <= next_col;
            tx_underrun_o   <= next_und;
        end
    end

    // Receive engine
    mni_rx_e  rx_state;
    mni_rx_e  next_rx_state;
    mni_nib_t rx_prev;
    mni_nib_t next_rx_prev;
    mni_nib_t rx_lo;
    mni_nib_t next_rx_lo;
    logic     rx_hi;
    logic     next_rx_hi;
    logic     rx_bad;
    logic     next_rx_bad;
    logic [7:0] next_rx_data;
    logic     next_rx_valid;
    logic     next_rx_end;
    logic     next_fcs_err;

    always_comb begin
        next_rx_state = rx_state;
        next_rx_prev  = rx_prev;
        next_rx_lo    = rx_lo;
        next_rx_hi    = rx_hi;
        next_rx_bad   = rx_bad;
        next_rx_data  = rx_data_o;
        next_rx_valid = 1'b0;
        next_rx_end   = 1'b0;
        next_fcs_err  = 1'b0;
        if (rx_tick) begin
            next_rx_prev = nib_s;
            unique case (rx_state)
                RX_IDLE: begin
                    if (dv_s) begin
                        next_rx_bad   = er_s;
                        next_rx_state = RX_HUNT;
                    end
                end
                RX_HUNT: begin
                    if (!dv_s) begin
                        next_rx_state = RX_IDLE;
                    end else begin
                        next_rx_bad = rx_bad | er_s;
                        // RULE8: one flag octet is enough
                        // RULE14: match 5 then D, ignore other patterns
                        if (rx_prev == `MNI_PRE_NIB && nib_s == `MNI_SFD_NIB) begin
                            next_rx_hi    = 1'b0;
                            next_rx_state = RX_DATA;
                        end
                    end
                end
                RX_DATA: begin
                    if (!dv_s) begin
                        // RULE12: errored frame reported as checksum error
                        next_rx_end   = 1'b1;
                        next_fcs_err  = rx_bad;
                        next_rx_state = RX_IDLE;
                    end else begin
                        next_rx_bad = rx_bad | er_s;
                        if (!rx_hi) begin
                            next_rx_lo = nib_s;
                            next_rx_hi = 1'b1;
                        end else begin
                            // RULE10: first nibble is the low half
                            next_rx_data  = {nib_s, rx_lo};
                            next_rx_valid = ~(rx_bad | er_s);
                            next_rx_hi    = 1'b0;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rx_state     <= RX_IDLE;
            rx_prev      <= '0;
            rx_lo        <= '0;
            rx_hi        <= 1'b0;
            rx_bad       <= 1'b0;
            rx_data_o    <= '0;
            rx_valid_o   <= 1'b0;
            rx_end_o     <= 1'b0;
            rx_fcs_err_o <= 1'b0;
        end else begin
            rx_state     <= next_rx_state;
            rx_prev      <= next_rx_prev;
            rx_lo        <= next_rx_lo;
            rx_hi        <= next_rx_hi;
            rx_bad       <= next_rx_bad;
            rx_data_o    <= next_rx_data;
            rx_valid_o   <= next_rx_valid;
            rx_end_o     <= next_rx_end;
            rx_fcs_err_o <= next_fcs_err;
        end
    end

    // Checks
    a_tx_start_pre: assert property ( // RULE2
        $rose(tx_enable_out_o) |-> txd_o == `MNI_PRE_NIB && tx_state == TX_PRE)
        else $error("transmit did not open with a preamble nibble");

    a_tx_edge_only: assert property ( // RULE4
        !tx_tick |=> $stable(tx_enable_out_o) && $stable(txd_o))
        else $error("transmit pins moved without a clock edge");

    a_tx_low_first: assert property ( // RULE3
        pop |=> txd_o == $past(bo_data[3:0]) ##0 tx_hi)
        else $error("low nibble not sent first");

    a_tx_end_last: assert property ( // RULE5
        $fell(tx_enable_out_o) |-> $past(tx_fin) || tx_underrun_o)
        else $error("enable dropped before the final nibble");

    a_tx_defer: assert property ( // RULE15
        $rose(tx_enable_out_o) |-> !$past(carrier_o))
        else $error("transmit started over carrier");

    a_col_sync: assert property ( // RULE6
        $rose(tx_collision_o) |-> $past(col_s) && $past(tx_enable_out_o))
        else $error("collision flagged without synchronised input");

    a_rx_flag: assert property ( // RULE14
        rx_state == RX_HUNT ##1 rx_state == RX_DATA |->
        $past(rx_prev) == `MNI_PRE_NIB && $past(nib_s) == `MNI_SFD_NIB)
        else $error("frame entered without 5 then D");

    a_rx_err_drop: assert property ( // RULE12
        rx_tick && dv_s && er_s && rx_state != RX_IDLE |=> rx_bad && !rx_valid_o)
        else $error("receive error did not poison the frame");

    a_rx_lsb: assert property ( // RULE10
        rx_valid_o |-> rx_data_o[3:0] == rx_lo)
        else $error("receive nibble order wrong");

    a_phy_isolate: assert property ( // RULE20
        external_phy_select_o || phy_interface_disable_o |=> int_phy_isolate_o)
        else $error("integrated PHY not isolated");
endmodule

// ### pkg/mni_defines.svh
// Constants for the MAC-side nibble interface
`ifndef MNI_DEFINES_SVH
`define MNI_DEFINES_SVH

// Preamble and opening flag nibbles
`define MNI_PRE_NIB      4'h5
`define MNI_SFD_NIB      4'hd
// Index of the flag nibble within the transmitted preamble
`define MNI_PRE_LAST     4'hf
`define MNI_CNT_FIRST    4'h1

// Integrated PHY management address
`define MNI_INT_PHY_ADDR 5'h00

// Reset values of the PHY selection controls
`define MNI_EXT_SEL_RST  1'b0
`define MNI_PHY_INTERFACE_DISABLE_RST  1'b1

// Bit positions in the synchroniser vector
`define MNI_SYNC_W       10
`define MNI_POS_TXC      9
`define MNI_POS_RXC      8
`define MNI_POS_COL      7
`define MNI_POS_CRS      6
`define MNI_POS_DV       5
`define MNI_POS_ER       4
`define MNI_POS_RXD_HI   3
`define MNI_POS_RXD_LO   0

// Buffer entry: byte plus end-of-frame marker
`define MNI_BUF_W        9

`endif

// ### pkg/mni_pkg.sv
// Types for the MAC-side nibble interface
package mni_pkg;

    typedef logic [3:0] mni_nib_t;

    typedef enum logic [2:0] {
        TX_IDLE = 3'b001,
        TX_PRE  = 3'b010,
        TX_DATA = 3'b100
    } mni_tx_e;

    typedef enum logic [2:0] {
        RX_IDLE = 3'b001,
        RX_HUNT = 3'b010,
        RX_DATA = 3'b100
    } mni_rx_e;

endpackage

// ### tb/mni_phy_model.sv
// Behavioural PHY facing the nibble interface
`timescale 1ns/1ps
module mni_phy_model (
    // Nibble clocks
    output logic       tx_clk_o,
    output logic       rx_clk_o,
    // Receive pins
    output logic       rx_dv_o,
    output logic       rx_er_o,
    output logic [3:0] rxd_o,
    // Line state
    output logic       col_o,
    output logic       crs_o,
    input  wire logic  col_req_i,
    // Transmit pins
    input  wire logic       tx_en_i,
    input  wire logic [3:0] txd_i
);
    logic [3:0] tx_q[$];
    int         tx_frames;
    logic       en_q;
    logic       busy;

    initial begin
        tx_clk_o = 1'b0;
        rx_clk_o = 1'b0;
        rx_dv_o = 1'b0;
        rx_er_o = 1'b0;
        rxd_o = 4'h0;
        col_o = 1'b0;
        tx_frames = 0;
        en_q = 1'b0;
        busy = 1'b0;
        #7;
        fork
            forever #100 tx_clk_o = ~tx_clk_o;
            begin
                #61;
                forever #100 rx_clk_o = ~rx_clk_o;
            end
        join
    end

    assign crs_o = tx_en_i | rx_dv_o | col_o;

    // Idle data lines keep changing so stale values are never trusted
    always @(negedge rx_clk_o) begin
        if (!busy) rxd_o <= ~rxd_o;
    end

    task automatic send_rx(input logic [3:0] nibs[$], input int er_at);
        busy = 1'b1;
        foreach (nibs[i]) begin
            @(negedge rx_clk_o);
            rx_dv_o = 1'b1;
            rx_er_o = (i == er_at);
            rxd_o = nibs[i];
        end
        @(negedge rx_clk_o);
        rx_dv_o = 1'b0;
        rx_er_o = 1'b0;
        busy = 1'b0;
        repeat (3) @(negedge rx_clk_o);
    endtask

    always @(posedge tx_clk_o) begin
        if (tx_en_i === 1'b1) tx_q.push_back(txd_i);
        if (en_q && tx_en_i === 1'b0) tx_frames++;
        en_q = (tx_en_i === 1'b1);
        col_o <= col_req_i;
    end
endmodule

// ### tb/test_mac_side_mii_nibble_interface.sv
// Self-checking bench for the MAC-side nibble interface
`timescale 1ns/1ps
module test_mac_side_mii_nibble_interface;
    typedef struct packed {logic [3:0] lo; logic [3:0] hi; logic [7:0] exp;} mni_row_s;
    logic       ref_clk_i, arst_n_i, external_phy_select_i, phy_disable_clear_i;
    logic       phy_disable_set_i, tx_valid_i, tx_last_i, col_req;
    logic [7:0] tx_data_i, rx_data_o;
    logic       tx_ready_o, tx_collision_o, tx_underrun_o, tx_enable_out_o, mii_tx_oe_o;
    logic [3:0] txd_o, rxd;
    logic       tx_clk, rx_clk, rx_dv, rx_er, col, crs;
    logic       rx_valid_o, rx_end_o, rx_fcs_err_o, carrier_o;
    logic       external_phy_select_o, phy_interface_disable_o, int_phy_isolate_o;
    logic [4:0] int_phy_addr_o;
    int         fails, checked, ends, bad, und, n;
    logic       stalled, saw_crs;
    logic [7:0] rx_q[$];
    logic [3:0] nq[$];
    mni_row_s   rows[4] = '{'{4'h1, 4'h2, 8'h21}, '{4'hf, 4'h0, 8'h0f},
                            '{4'ha, 4'h5, 8'h5a}, '{4'h0, 4'hd, 8'hd0}};

    mni_top dut_u (
        .ref_clk_i, .arst_n_i, .external_phy_select_i, .phy_disable_clear_i,
        .phy_disable_set_i, .tx_data_i, .tx_valid_i, .tx_last_i, .tx_ready_o,
        .tx_collision_o, .tx_underrun_o, .tx_nibble_clock_i(tx_clk), .collision_in_i(col),
        .carrier_sense_in_i(crs), .tx_enable_out_o, .txd_o, .mii_tx_oe_o,
        .rx_nibble_clock_i(rx_clk), .rx_dv_i(rx_dv), .rx_er_i(rx_er), .rxd_i(rxd),
        .rx_data_o, .rx_valid_o, .rx_end_o, .rx_fcs_err_o, .carrier_o,
        .external_phy_select_o, .phy_interface_disable_o, .int_phy_isolate_o,
        .int_phy_addr_o
    );

    mni_phy_model phy_u (
        .tx_clk_o(tx_clk), .rx_clk_o(rx_clk), .rx_dv_o(rx_dv), .rx_er_o(rx_er),
        .rxd_o(rxd), .col_o(col), .crs_o(crs), .col_req_i(col_req),
        .tx_en_i(tx_enable_out_o), .txd_i(txd_o)
    );

    task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_cnt(input int got, input int exp);
        checked++;
        if (got != exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // Hold each byte until the buffer takes it
    task automatic push(input logic [7:0] d, input logic l);
        tx_data_i <= d;
        tx_last_i <= l;
        tx_valid_i <= 1'b1;
        @(posedge ref_clk_i);
        while (tx_ready_o !== 1'b1) @(posedge ref_clk_i);
    endtask

    initial begin
        ref_clk_i = 1'b0;
        forever #12.5 ref_clk_i = ~ref_clk_i;
    end

    always @(posedge ref_clk_i) begin
        if (rx_valid_o === 1'b1) rx_q.push_back(rx_data_o);
        if (rx_end_o === 1'b1) ends++;
        if (rx_fcs_err_o === 1'b1) bad++;
        if (tx_underrun_o === 1'b1) und++;
        if (carrier_o === 1'b1) saw_crs = 1'b1;
        if (tx_valid_i === 1'b1 && tx_ready_o === 1'b0) stalled = 1'b1;
    end

    initial begin
        #200000;
        fails++;
        wrap_up();
    end

    initial begin
        {arst_n_i, external_phy_select_i, phy_disable_clear_i, phy_disable_set_i} = 4'h0;
        {tx_valid_i, tx_last_i, col_req, stalled, saw_crs} = 5'h00;
        tx_data_i = 8'h00;
        repeat (3) @(posedge ref_clk_i);
        arst_n_i <= 1'b1;
        repeat (6) @(posedge ref_clk_i);
        chk_val(8'(external_phy_select_o), 8'h00);
        chk_val(8'(phy_interface_disable_o), 8'h01);
        chk_val(8'(int_phy_isolate_o), 8'h01);
        chk_val(8'(int_phy_addr_o), 8'h00);
        // Junk nibble, one flag octet, then the table as payload
        nq = '{4'h3, 4'h5, 4'hd};
        foreach (rows[i]) begin
            nq.push_back(rows[i].lo);
            nq.push_back(rows[i].hi);
        end
        phy_u.send_rx(nq, -1);
        @(posedge ref_clk_i);
        fork
            begin
                foreach (rows[i]) push(rows[i].exp, i == 3);
                tx_valid_i <= 1'b0;
            end
            begin
                repeat (60) @(posedge ref_clk_i);
                col_req <= 1'b1;
                for (n = 0; n < 200 && tx_collision_o !== 1'b1; n++) @(posedge ref_clk_i);
                chk_val(8'(tx_collision_o), 8'h01);
                col_req <= 1'b0;
            end
        join
        for (n = 0; n < 1000 && phy_u.tx_frames < 1; n++) @(posedge ref_clk_i);
        chk_cnt(phy_u.tx_frames, 1);
        chk_cnt(phy_u.tx_q.size(), 24);
        chk_val(8'(phy_u.tx_q[0]), 8'h05);
        chk_val(8'(phy_u.tx_q[15]), 8'h0d);
        chk_cnt(rx_q.size(), 4);
        foreach (rows[i]) begin
            chk_val(rx_q[i], rows[i].exp);
            chk_val(8'(phy_u.tx_q[16 + 2 * i]), 8'(rows[i].lo));
            chk_val(8'(phy_u.tx_q[17 + 2 * i]), 8'(rows[i].hi));
        end
        chk_val(8'(stalled), 8'h01); // buffer refusal seen
        chk_cnt(und, 0);
        chk_val(8'(saw_crs), 8'h01);
        // Error on the first payload nibble, then a frame cut before its flag
        phy_u.send_rx('{4'h5, 4'hd, 4'h1, 4'h2}, 2);
        phy_u.send_rx('{4'h5, 4'h5, 4'h5}, -1);
        repeat (20) @(posedge ref_clk_i);
        chk_cnt(rx_q.size(), 4);
        chk_cnt(ends, 2);
        chk_cnt(bad, 1);
        // Source runs dry after one byte: frame is cut and flagged
        push(8'h5a, 1'b0);
        tx_valid_i <= 1'b0;
        for (n = 0; n < 1000 && phy_u.tx_frames < 2; n++) @(posedge ref_clk_i);
        chk_cnt(phy_u.tx_frames, 2);
        chk_cnt(und, 1);
        chk_cnt(phy_u.tx_q.size(), 42);
        chk_val(8'(phy_u.tx_q[40]), 8'h0a);
        phy_disable_clear_i <= 1'b1;
        @(posedge ref_clk_i);
        phy_disable_clear_i <= 1'b0;
        repeat (3) @(posedge ref_clk_i);
        chk_val(8'(phy_interface_disable_o), 8'h00);
        chk_val(8'(int_phy_isolate_o), 8'h00);
        external_phy_select_i <= 1'b1;
        repeat (3) @(posedge ref_clk_i);
        chk_val(8'(external_phy_select_o), 8'h01);
        chk_val(8'(int_phy_isolate_o), 8'h01);
        chk_val(8'(mii_tx_oe_o), 8'h01);
        {phy_disable_set_i, phy_disable_clear_i} <= 2'h3;
        @(posedge ref_clk_i);
        {phy_disable_set_i, phy_disable_clear_i} <= 2'h0;
        repeat (3) @(posedge ref_clk_i);
        chk_val(8'(phy_interface_disable_o), 8'h01);
        // Second reset in mid-run restores the defaults
        arst_n_i <= 1'b0;
        repeat (2) @(posedge ref_clk_i);
        chk_val(8'(external_phy_select_o), 8'h00);
        chk_val(8'(phy_interface_disable_o), 8'h01);
        chk_val(8'(tx_ready_o), 8'h01); // buffer empty after reset
        arst_n_i <= 1'b1;
        repeat (4) @(posedge ref_clk_i);
        wrap_up();
    end
endmodule
